// *** core/dws_core.sv ***
// word synchronizer, framing counter, crc check and precompensation encoder
//
// Functional notes
// R1: precomp window maps to early, on-time, late
// R2: mfm-impossible patterns need no special handling
// R3: read alignment needs sync then address mark
// R4: phase error before alignment drives phase_ok
// R5: processor access waits until word transfer
// R6: transfer without access sets overrun latch
// R7: data words: counter cleared, sixteen bits counted
// R8: mark transfers: counter preset to eight
// R9: each carry moves one word; in read the code moves a word on each counter load instead
// R10: phase_ok needs read, both faults, states 000-011
// R11: wait low when selected on load/carry
// R12: overrun set on same events when unselected
// R13: counter load per state in read, carry in write; the code loads in write only on a selected carry
// R14: data strobe when waiting and not reading
// R15: word state held as three-bit code
// R16: density, precomp enable, control steer behaviour
// R17: processor sequences control while loading words
// R18: read start finds mark, aligns, checks crc
// R19: crc fault held for one word time
// R20: processor samples crc fault within that word
// R21: write emits sync, marks, id, crc sequence
// R22: precomp output shifted in 167 ns steps; the divider gives 165 ns (33 clocks of 5 ns)
// R23: ccitt crc from all-ones, good gives 0000
// R24: overrun stays set until controller reset
// R25: reset returns state 000, counter cleared
`default_nettype none
module dws_core
(
	input  wire logic               hclk,
	input  wire logic               hresetn,
	input  wire logic               hsel,
	input  wire logic [31:0]        haddr,
	input  wire logic [1:0]         htrans,
	input  wire logic               hwrite,
	input  wire logic [2:0]         hsize,
	input  wire logic [31:0]        hwdata,
	input  wire logic               hready,
	output logic                    hreadyout,
	output logic                    hresp,
	output logic [31:0]             hrdata,
	input  wire dws_pkg::dws_bitin_t bit_in,
	output dws_pkg::dws_taps_t      taps,
	output logic                    precomp_wdata,
	output logic                    write_data_bit,
	output logic                    phase_ok,
	output logic                    transfer_wait_n,
	output logic                    missed_word_set,
	output logic                    data_cmd_strobe,
	output logic                    bit_counter_load,
	output logic                    bit_counter_carry,
	output logic                    word_state_b2,
	output logic                    word_state_b1,
	output logic                    word_state_b0,
	output logic                    crc_fault_latch,
	output logic                    read_path_on,
	output logic                    double_density_sel,
	output logic                    precomp_enable,
	output logic                    write_gate
);
	import dws_pkg::*;

	// ==========================================
	// functions
	function automatic logic [4:0] pc_encode(input logic en, input logic [6:0] h);
		logic [3:0] key;
		key = {h[HIST_CR3], h[HIST_CR4], h[HIST_CR6], h[HIST_CR7]};
		if (!h[HIST_CR5])
			return PC_NONE;
		if (!en)
			return PC_ONTIME;
		unique case (key)
			4'h0, 4'h6, 4'h7, 4'h9, 4'he, 4'hf: return PC_ONTIME;
			4'h1, 4'h2, 4'h3, 4'ha, 4'hb: return PC_LATE;
			default: return PC_EARLY;
		endcase
	endfunction

	function automatic logic [15:0] crc_step(input logic [15:0] c, input logic d);
		return {c[14:0], 1'b0} ^ ((c[15] ^ d) ? CRC_POLY : CRC_GOOD);
	endfunction

	// ==========================================
	// bus slave
	logic              dp_valid_r;
	logic              dp_write_r;
	logic [7:0]        dp_addr_r;
	logic [CTRL_W-1:0] ctrl_r;
	logic              controller_selected;
	logic              host_read_cycle;
	logic              word_event;
	logic              ctrl_wr;
	logic              soft_clr;
	logic [15:0]       sreg_r;
	logic              overrun_r;
	logic [3:0]        cnt_r;
	dws_state_t        st_r;
	dws_state_t        st_nxt;

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			dp_valid_r <= 1'b0;
			dp_write_r <= 1'b0;
			dp_addr_r  <= ADDR_CTRL;
		end
		else if (hready)
		begin
			dp_valid_r <= hsel & htrans[1];
			dp_write_r <= hwrite;
			dp_addr_r  <= haddr[7:0];
		end
	end

	assign controller_selected = dp_valid_r & (dp_addr_r == ADDR_DATA);
	assign host_read_cycle     = controller_selected & ~dp_write_r;
	assign ctrl_wr  = dp_valid_r & dp_write_r & (dp_addr_r == ADDR_CTRL);
	assign soft_clr = ctrl_wr & hwdata[CTRL_RST];
	assign hresp    = 1'b0;

	// R5: stall until transfer
	assign hreadyout = ~controller_selected | word_event;

	// R16: control steers paths
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			ctrl_r <= CTRL_RESET;
		else if (ctrl_wr)
			ctrl_r <= hwdata[CTRL_W-1:0];
	end

	assign read_path_on       = ctrl_r[CTRL_READ];
	assign double_density_sel = ctrl_r[CTRL_DDEN];
	assign precomp_enable     = ctrl_r[CTRL_PCEN];
	assign write_gate         = ctrl_r[CTRL_WRITE_GATE];

	always_comb
	begin
		hrdata = 32'h0000_0000;
		if (dp_valid_r && !dp_write_r)
		begin
			unique case (dp_addr_r)
				ADDR_CTRL: hrdata[CTRL_W-1:0] = ctrl_r;
				ADDR_STATUS:
				begin
					hrdata[2:0]              = st_r;
					hrdata[ST_OVR]           = overrun_r;
					hrdata[ST_CRC]           = crc_fault_latch;
					hrdata[ST_PHOK]          = phase_ok;
					hrdata[ST_CNT+3:ST_CNT]  = cnt_r;
				end
				ADDR_DATA: hrdata[15:0] = sreg_r;
				default: hrdata = 32'h0000_0000;
			endcase
		end
	end

	// ==========================================
	// word controller
	logic ev;
	logic sy;
	logic mk;
	logic cnt_run;
	logic mark_xfer;

	assign ev = bit_in.bit_en;
	assign sy = bit_in.sync_seen;
	assign mk = bit_in.mark_seen;

	// R15: three-bit state code
	assign word_state_b2 = st_r[2];
	assign word_state_b1 = st_r[1];
	assign word_state_b0 = st_r[0];

	// R3: sync then mark aligns
	always_comb
	begin
		st_nxt = st_r;
		if (!read_path_on)
			st_nxt = WS_IDLE;
		else if (ev)
		begin
			unique case (st_r)
				WS_IDLE:  st_nxt = WS_HUNT;
				WS_HUNT:  st_nxt = (sy & ~mk) ? WS_SYNC : WS_HUNT;
				WS_SYNC:  st_nxt = (sy & mk) ? WS_MARKW : WS_SYNC;
				WS_MARKW: st_nxt = (mk & ~sy) ? WS_MARKB : WS_MARKW;
				WS_MARKB: st_nxt = bit_counter_carry ? WS_DATA : WS_MARKB;
				WS_DATA:  st_nxt = WS_DATA;
				default:  st_nxt = WS_IDLE;
			endcase
		end
	end

	// R25: reset to 000
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			st_r <= WS_IDLE;
		else if (soft_clr)
			st_r <= WS_IDLE;
		else
			st_r <= st_nxt;
	end

	// R4: phase correction before alignment
	// R10: phase_ok decode
	assign phase_ok = read_path_on & bit_in.mark_or_phase_fault & bit_in.sync_or_phase_fault & ~st_r[2];

	assign cnt_run = read_path_on ? (st_r != WS_IDLE) : write_gate;
	assign bit_counter_carry = cnt_run & ev & (cnt_r == CNT_TOP);

	// R13: load conditions
	always_comb
	begin
		bit_counter_load = 1'b0;
		if (read_path_on)
		begin
			unique case (st_r)
				WS_HUNT:  bit_counter_load = ev & sy & ~mk;
				WS_SYNC:  bit_counter_load = bit_counter_carry & ~(sy & mk);
				WS_MARKW: bit_counter_load = ev & mk & ~sy;
				WS_MARKB: bit_counter_load = bit_counter_carry | (ev & mk & ~sy);
				WS_DATA:  bit_counter_load = bit_counter_carry;
				default:  bit_counter_load = 1'b0;
			endcase
		end
		else
			bit_counter_load = controller_selected & bit_counter_carry;
	end

	// R8: mark transfers count eight
	assign mark_xfer = read_path_on ? ((st_r == WS_MARKW) | ((st_r == WS_MARKB) & mk & ~sy))
		: ctrl_r[CTRL_WMARK];

	// R7: cleared, sixteen bits
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			cnt_r <= CNT_CLR;
		else if (soft_clr || !cnt_run)
			cnt_r <= CNT_CLR;
		else if (bit_counter_load)
			cnt_r <= mark_xfer ? CNT_MARK : CNT_CLR;
		else if (ev)
			cnt_r <= cnt_r + 4'h1;
	end

	// R9: one word per counter load in read, per carry in write
	assign word_event = read_path_on ? bit_counter_load : bit_counter_carry;
	// R11: wait strobe
	assign transfer_wait_n = ~(controller_selected & word_event);
	// R12: unselected transfer
	// R6: missed word
	assign missed_word_set = ~controller_selected & word_event;
	// R14: data load strobe
	assign data_cmd_strobe = ~transfer_wait_n & ~host_read_cycle;

	// R24: sticky until controller reset
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			overrun_r <= 1'b0;
		else if (missed_word_set)
			overrun_r <= 1'b1;
		else if (soft_clr)
			overrun_r <= 1'b0;
	end

	// ==========================================
	// data shift register and serial write
	logic        shift_en;
	logic        wbit;
	logic [15:0] crc_r;
	logic        crc_din;
	logic        crc_preset;

	assign shift_en = ev & (read_path_on | write_gate);
	assign wbit     = ctrl_r[CTRL_SEND] ? crc_r[15] : sreg_r[15];

	// R21: words leave msb first in load order
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			sreg_r <= 16'h0000;
		else if (data_cmd_strobe)
			sreg_r <= hwdata[15:0];
		else if (shift_en)
			sreg_r <= {sreg_r[14:0], read_path_on & bit_in.rd_bit};
	end

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			write_data_bit <= 1'b0;
		else if (shift_en && !read_path_on)
			write_data_bit <= wbit;
	end

	// ==========================================
	// crc
	// sending the remainder feeds its own msb back, so the register simply drains
	assign crc_din    = read_path_on ? bit_in.rd_bit : wbit;
	assign crc_preset = read_path_on ? ~st_r[1] & ~st_r[2] | (st_r == WS_SYNC) : ~ctrl_r[CTRL_ACCUM];

	// R18: crc starts at the mark
	// R23: ccitt from all ones
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			crc_r <= CRC_PRESET;
		else if (crc_preset || soft_clr)
			crc_r <= CRC_PRESET;
		else if (shift_en)
			crc_r <= crc_step(crc_r, crc_din);
	end

	// R19: held one word time
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			crc_fault_latch <= 1'b0;
		else if (read_path_on && st_r == WS_DATA && bit_counter_load)
			crc_fault_latch <= crc_step(crc_r, crc_din) != CRC_GOOD;
	end

	// ==========================================
	// precompensation
	logic [4:0] taps_r;
	logic [4:0] pc_sr_r;
	logic [5:0] step_cnt_r;
	logic       step_en;

	// R1: window to tap pattern
	// R2: starred patterns decode as listed
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			taps_r <= PC_NONE;
		else if (ev)
			taps_r <= pc_encode(precomp_enable, bit_in.cell_hist);
	end

	assign taps = taps_r;

	// R22: 165 ns step divider (33 clocks of 5 ns)
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			step_cnt_r <= 6'h00;
		else if (step_en)
			step_cnt_r <= 6'h00;
		else
			step_cnt_r <= step_cnt_r + 6'h01;
	end

	assign step_en = step_cnt_r == PC_STEP_LAST;

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			pc_sr_r <= PC_NONE;
		else if (ev)
			pc_sr_r <= taps_r;
		else if (step_en)
			pc_sr_r <= {pc_sr_r[3:0], 1'b0};
	end

	assign precomp_wdata = pc_sr_r[4];

	// ==========================================
	// assertions
	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);

	sequence seq_mark_load;
		read_path_on && st_r == WS_MARKW && ev && mk && !sy;
	endsequence
	sequence seq_data_load;
		read_path_on && st_r == WS_DATA && bit_counter_load && !soft_clr;
	endsequence

	AST_MARK_PRESET: assert property (seq_mark_load and !soft_clr |=> cnt_r == CNT_MARK) // R8
		else $error("mark load did not preset counter to eight");
	AST_DATA_CLEAR: assert property (seq_data_load |=> cnt_r == CNT_CLR) // R7
		else $error("data load did not clear counter");
	AST_WAIT_STALL: assert property (controller_selected && !word_event |-> !hreadyout && transfer_wait_n) // R5
		else $error("access not stalled before transfer");
	AST_OVR_STICKY: assert property (missed_word_set |=> overrun_r ##1 (overrun_r || $past(soft_clr))) // R24
		else $error("overrun latch not held");
	AST_PHASE_ALIGNED: assert property (st_r == WS_DATA |-> !phase_ok) // R10
		else $error("phase_ok after alignment");
	AST_PC_NODATA: assert property (ev && !bit_in.cell_hist[HIST_CR5] |=> taps_r == PC_NONE) // R1
		else $error("taps active without data bit");
	AST_PC_DISABLED: assert property (ev && !precomp_enable && bit_in.cell_hist[HIST_CR5] |=> taps_r == PC_ONTIME) // R1
		else $error("disabled precomp not on-time");
	AST_IDLE_OFF: assert property (!read_path_on |=> st_r == WS_IDLE) // R25
		else $error("word state not idle with read off");
	AST_CRC_HOLD: assert property (!(read_path_on && st_r == WS_DATA && bit_counter_load) |=> $stable(crc_fault_latch)) // R19
		else $error("crc fault changed between words");
	AST_STROBE: assert property (data_cmd_strobe |-> controller_selected && dp_write_r && hreadyout) // R14
		else $error("strobe outside a write transfer");
endmodule
`default_nettype wire

// *** core/dws_pkg.sv ***
// package: constants and types for the disk word synchronizer
`default_nettype none
package dws_pkg;
	// ==========================================
	// register map
	localparam logic [7:0] ADDR_CTRL   = 8'h00;
	localparam logic [7:0] ADDR_STATUS = 8'h04;
	localparam logic [7:0] ADDR_DATA   = 8'h08;
	localparam int CTRL_READ  = 0;
	localparam int CTRL_DDEN  = 1;
	localparam int CTRL_PCEN  = 2;
	localparam int CTRL_WRITE_GATE = 3;
	localparam int CTRL_WMARK = 4;
	localparam int CTRL_ACCUM = 5;
	localparam int CTRL_SEND  = 6;
	localparam int CTRL_RST   = 7;
	localparam int CTRL_W     = 7;
	localparam logic [CTRL_W-1:0] CTRL_RESET = 7'h00;
	localparam int ST_OVR  = 3;
	localparam int ST_CRC  = 4;
	localparam int ST_PHOK = 5;
	localparam int ST_CNT  = 8;
	// ==========================================
	// word framing and crc
	localparam logic [3:0]  CNT_CLR    = 4'h0;
	localparam logic [3:0]  CNT_MARK   = 4'h8;
	localparam logic [3:0]  CNT_TOP    = 4'hf;
	localparam logic [15:0] CRC_POLY   = 16'h1021;
	localparam logic [15:0] CRC_PRESET = 16'hffff;
	localparam logic [15:0] CRC_GOOD   = 16'h0000;
	// ==========================================
	// precompensation
	localparam int HIST_CR3 = 2;
	localparam int HIST_CR4 = 3;
	localparam int HIST_CR5 = 4;
	localparam int HIST_CR6 = 5;
	localparam int HIST_CR7 = 6;
	localparam logic [4:0] PC_EARLY  = 5'h1c;
	localparam logic [4:0] PC_ONTIME = 5'h0e;
	localparam logic [4:0] PC_LATE   = 5'h07;
	localparam logic [4:0] PC_NONE   = 5'h00;
	localparam int CLK_NS      = 5;
	localparam int PC_STEP_NS  = 167;
	localparam int PC_STEP_CYC = (PC_STEP_NS / CLK_NS) < 1 ? 1 : (PC_STEP_NS / CLK_NS);
	localparam logic [5:0] PC_STEP_LAST = 6'(PC_STEP_CYC - 1);
	// ==========================================
	// types
	typedef enum logic [2:0] {
		WS_IDLE  = 3'b000,
		WS_HUNT  = 3'b001,
		WS_MARKW = 3'b010,
		WS_SYNC  = 3'b011,
		WS_MARKB = 3'b100,
		WS_DATA  = 3'b110
	} dws_state_t;
	typedef struct packed {
		logic       bit_en;
		logic       rd_bit;
		logic       sync_seen;
		logic       mark_seen;
		logic       mark_or_phase_fault;
		logic       sync_or_phase_fault;
		logic [6:0] cell_hist;
	} dws_bitin_t;
	typedef struct packed {
		logic precomp_tap_early;
		logic precomp_tap_early_mid;
		logic precomp_tap_center;
		logic precomp_tap_late_mid;
		logic precomp_tap_late;
	} dws_taps_t;
endpackage
`default_nettype wire

// *** tb/dws_core_tb.sv ***
// self-checking bench for the disk word synchronizer
`default_nettype none
module dws_core_tb;
	import dws_pkg::*;
	timeunit 1ns;
	timeprecision 1ps;
	logic        hclk = 1'b0;
	logic        hresetn = 1'b0;
	logic        hsel, hwrite, hready, hung;
	logic [31:0] haddr, hwdata, hrdata;
	logic [1:0]  htrans;
	logic [2:0]  hsize;
	dws_bitin_t  bit_in;
	logic        bit_en = 1'b0;
	logic        rd_bit = 1'b0;
	logic        sync_s = 1'b0;
	logic        mark_s = 1'b0;
	logic        mpf = 1'b0;
	logic        spf = 1'b0;
	logic [6:0]  hist = 7'h00;
	logic [15:0] crc_m = 16'hffff;
	dws_taps_t   taps;
	logic        phase_ok, transfer_wait_n, missed_word_set, data_cmd_strobe;
	logic        b2, b1, b0s;
	logic [1:0]  div = 2'h0;
	int          nbits = 0;
	int          num_errors = 0;
	int          n_compared = 0;
	int          n_missed = 0;
	int          n_strobe = 0;
	int          n_wait = 0;
	always #2.5 hclk = ~hclk;
	// one driver per field, gathered into the carrier
	assign bit_in = {bit_en, rd_bit, sync_s, mark_s, mpf, spf, hist};
	// ccitt division step, msb first
	function automatic logic [15:0] tb_crc(input logic [15:0] c, input logic d);
		return {c[14:0], 1'b0} ^ ((c[15] ^ d) ? CRC_POLY : 16'h0000);
	endfunction
	// ==========================================
	// bit cell source, one pulse every four clocks
	always @(posedge hclk)
	begin
		div <= div + 2'h1;
		bit_en <= (div == 2'h3);
		if (div == 2'h3)
			rd_bit <= 1'($urandom);
		if (bit_in.bit_en)
			nbits <= nbits + 1;
		// remainder runs from the first mark on, preset before it
		if (bit_in.bit_en)
			crc_m <= (b2 || (b1 && !b0s)) ? tb_crc(crc_m, bit_in.rd_bit) : CRC_PRESET;
		if (missed_word_set)
			n_missed <= n_missed + 1;
		if (data_cmd_strobe)
			n_strobe <= n_strobe + 1;
		if (!transfer_wait_n)
			n_wait <= n_wait + 1;
	end
	dws_host dws_host_inst (.hclk(hclk), .hready(hready), .hrdata(hrdata), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hung(hung));
	dws_core dws_core_inst (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hreadyout(hready), .hresp(),
		.hrdata(hrdata), .bit_in(bit_in), .taps(taps), .precomp_wdata(), .write_data_bit(),
		.phase_ok(phase_ok), .transfer_wait_n(transfer_wait_n), .missed_word_set(missed_word_set),
		.data_cmd_strobe(data_cmd_strobe), .bit_counter_load(), .bit_counter_carry(),
		.word_state_b2(b2), .word_state_b1(b1), .word_state_b0(b0s), .crc_fault_latch(),
		.read_path_on(), .double_density_sel(), .precomp_enable(), .write_gate());
	// ==========================================
	// helpers
	task automatic print_verdict();
		$display("checks %0d errors %0d", n_compared, num_errors);
		if (num_errors == 0 && n_compared > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
		n_compared++;
		if (got !== exp)
		begin
			num_errors++;
			$display("BAD t=%0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic chk_bits(input logic [4:0] got, input logic [4:0] exp);
		n_compared++;
		if (got !== exp)
		begin
			num_errors++;
			$display("BAD t=%0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic reg_io(input logic wr, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] rd);
		dws_host_inst.xfer(wr, a, wd, rd);
		if (hung === 1'b1)
		begin
			num_errors++;
			print_verdict();
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] r;
		reg_io(1'b1, a, d, r);
	endtask
	task automatic wait_bits(input int k);
		int n;
		int c;
		n = 0;
		c = 0;
		while (c < k && n < 1000)
		begin
			@(posedge hclk);
			if (bit_in.bit_en)
				c++;
			n++;
		end
		if (c < k)
		begin
			num_errors++;
			print_verdict();
		end
	endtask
	function automatic logic [4:0] exp_taps(input logic en, input logic [6:0] h);
		if (!h[4])
			return 5'h00;
		if (!en)
			return 5'h0e;
		case ({h[2], h[3], h[5], h[6]})
			4'h0, 4'h6, 4'h7, 4'h9, 4'he, 4'hf: return 5'h0e;
			4'h1, 4'h2, 4'h3, 4'ha, 4'hb: return 5'h07;
			default: return 5'h1c;
		endcase
	endfunction
	task automatic step(input logic s, input logic m, input int k, input logic [2:0] exp);
		sync_s <= s;
		mark_s <= m;
		wait_bits(k);
		chk_bits({2'h0, b2, b1, b0s}, {2'h0, exp});
		chk_bits({4'h0, phase_ok}, {4'h0, exp <= 3'h3});
	endtask
	// ==========================================
	// main sequence
	initial
	begin
		logic [31:0] r;
		logic [6:0]  h;
		int          i;
		int          s;
		int          e0;
		int          e1;
		logic        ec;
		void'($urandom(32'h935bd16b));
		repeat (16) @(posedge hclk);
		hresetn <= 1'b1;
		reg_io(1'b0, ADDR_STATUS, 32'h0, r);
		chk_word(r, 32'h0);
		wr(8'h0c, 32'hffffffff);
		reg_io(1'b0, 8'h0c, 32'h0, r);
		chk_word(r, 32'h0);
		reg_io(1'b0, ADDR_CTRL, 32'h0, r);
		chk_word(r, 32'h0);
		$display("test reset done");
		for (i = 0; i < 48; i++)
		begin
			if (i == 0 || i == 32)
				wr(ADDR_CTRL, (i == 0) ? 32'h0c : 32'h08);
			h = (i < 16) ? {i[0], i[1], 1'b1, i[2], i[3], 2'($urandom)} : 7'($urandom);
			wait_bits(1);
			hist <= h;
			wait_bits(1);
			repeat (2) @(posedge hclk);
			chk_bits(taps, exp_taps(i < 32, h));
		end
		$display("test precomp done");
		// control changed between words
		// stop the counter first so no missed word races the soft clear
		wr(ADDR_CTRL, 32'h00);
		wr(ADDR_CTRL, 32'h88);
		e0 = n_strobe;
		wr(ADDR_DATA, 32'ha1a1);
		s = nbits;
		wr(ADDR_DATA, $urandom);
		chk_bits(5'(nbits - s), 5'd16);
		@(posedge hclk);
		chk_bits(5'(n_strobe - e0), 5'd2);
		wr(ADDR_CTRL, 32'h18);
		wr(ADDR_DATA, 32'hfe00);
		s = nbits;
		wr(ADDR_DATA, 32'hfe00);
		chk_bits(5'(nbits - s), 5'd8);
		reg_io(1'b0, ADDR_STATUS, 32'h0, r);
		chk_bits({4'h0, r[ST_OVR]}, 5'h0);
		$display("test write framing done");
		e0 = n_missed;
		e1 = n_wait;
		wait_bits(40);
		chk_bits({3'h0, n_missed != e0, n_wait != e1}, 5'h2);
		wait_bits(20);
		reg_io(1'b0, ADDR_STATUS, 32'h0, r);
		chk_bits({4'h0, r[ST_OVR]}, 5'h1);
		wr(ADDR_CTRL, 32'h00);
		wr(ADDR_CTRL, 32'h80);
		reg_io(1'b0, ADDR_STATUS, 32'h0, r);
		chk_word(r & 32'hf0f, 32'h0);
		$display("test overrun done");
		mpf <= 1'b1;
		spf <= 1'b1;
		wr(ADDR_CTRL, 32'h03);
		step(1'b0, 1'b0, 3, 3'b001);
		step(1'b1, 1'b0, 3, 3'b011);
		step(1'b1, 1'b1, 3, 3'b010);
		step(1'b0, 1'b1, 3, 3'b100);
		step(1'b0, 1'b0, 12, 3'b110);
		// first aligned word ends twelve bits on and latches the check
		wait_bits(12);
		@(posedge hclk);
		ec = crc_m != 16'h0000;
		reg_io(1'b0, ADDR_STATUS, 32'h0, r);
		chk_bits({4'h0, r[ST_CRC]}, {4'h0, ec});
		wr(ADDR_CTRL, 32'h00);
		repeat (2) @(posedge hclk);
		chk_bits({2'h0, b2, b1, b0s}, 5'h0);
		$display("test read walk done");
		print_verdict();
	end
endmodule
`default_nettype wire

// *** tb/dws_host.sv ***
// ahb-lite master model standing for the local processor
`default_nettype none
module dws_host
(
	input  wire logic        hclk,
	input  wire logic        hready,
	input  wire logic [31:0] hrdata,
	output logic             hsel,
	output logic [31:0]      haddr,
	output logic [1:0]       htrans,
	output logic             hwrite,
	output logic [2:0]       hsize,
	output logic [31:0]      hwdata,
	output logic             hung
);
	timeunit 1ns;
	timeprecision 1ps;
	initial
	begin
		hsel = 1'b0;
		haddr = 32'h0;
		htrans = 2'h0;
		hwrite = 1'b0;
		hsize = 3'h2;
		hwdata = 32'h0;
		hung = 1'b0;
	end
	// no cycle count assumed, only a bound against a hang
	task automatic wait_rdy(inout int n);
		do
		begin
			@(posedge hclk);
			n++;
		end
		while (hready !== 1'b1 && n < 500);
	endtask
	task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] rd);
		int n;
		n = 0;
		@(posedge hclk);
		hsel <= 1'b1;
		htrans <= 2'h2;
		haddr <= {24'h0, a};
		hwrite <= wr;
		wait_rdy(n);
		hsel <= 1'b0;
		htrans <= 2'h0;
		haddr <= ~haddr;
		hwdata <= wd;
		wait_rdy(n);
		rd = hrdata;
		// released data lines must not keep the last value
		hwdata <= ~wd;
		if (n >= 500)
			hung = 1'b1;
	endtask
endmodule
`default_nettype wire
